// [rtl/bpf_pkg.sv]
package bpf_pkg;
   // ----------------------------------------------------------------
   // protection states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      BPF_NORMAL     = 3'b000,
      BPF_OVERCHARGE = 3'b001,
      BPF_OVERDISCH  = 3'b010,
      BPF_DISCH_OC   = 3'b011,
      BPF_SHORT      = 3'b100,
      BPF_CHARGE_OC  = 3'b101
   } bpf_state_e;

   // ----------------------------------------------------------------
   // timing: figures in microseconds, counts at the 10 MHz clock
   // ----------------------------------------------------------------
   localparam int BPF_CLK_MHZ          = 10;
   localparam int BPF_OVERCHARGE_US    = 1000;
   localparam int BPF_OVERDISCH_US     = 100;
   localparam int BPF_OD_RELEASE_US    = 100;
   localparam int BPF_DISCH_OC_US      = 10;
   localparam int BPF_SHORT_US         = 2;
   localparam int BPF_CHARGE_OC_US     = 10;
   localparam int BPF_OVERCHARGE_CYC   = BPF_OVERCHARGE_US * BPF_CLK_MHZ;
   localparam int BPF_OVERDISCH_CYC    = BPF_OVERDISCH_US * BPF_CLK_MHZ;
   localparam int BPF_OD_RELEASE_CYC   = BPF_OD_RELEASE_US * BPF_CLK_MHZ;
   localparam int BPF_DISCH_OC_CYC     = BPF_DISCH_OC_US * BPF_CLK_MHZ;
   localparam int BPF_SHORT_CYC        = BPF_SHORT_US * BPF_CLK_MHZ;
   localparam int BPF_CHARGE_OC_CYC    = BPF_CHARGE_OC_US * BPF_CLK_MHZ;
   localparam int BPF_TIMER_W          = 20;
   localparam logic [2:0] BPF_SYNC_RST = 3'h0;
   localparam logic [2:0] BPF_WARM_CYC = 3'h4;
endpackage

// [rtl/bpf_battery_protection_fsm.sv]
`timescale 1ns/1ps
// What this block does
// - normal: both switches on, no pulls
// - overcharge held past delay blocks charging
// - overcharge state: both pulls disconnected
// - below-doc sense and below release: exit overcharge
// - at-doc sense and below detect: exit overcharge
// - overdischarge held past delay blocks discharging
// - overdischarge: pull-up on, pull-down off
// - power-down variant exits only while charging
// - charger sense and above detect: exit overdischarge
// - otherwise stay until cell above release level
// - auto-wakeup: release level held past delay
// - discharge overcurrent held past delay blocks discharging
// - short held past delay blocks discharging
// - overcurrent or short: pull-down on only
// - release overcurrent when sense returns near ground
// - charge overcurrent held past delay blocks charging
// - zero-volt option permits or blocks charging
// - overvoltage charger blocks charging, hysteresis release
// - overvoltage charger acts without delay
// - power-down variant sleeps in overdischarge
// - auto-wakeup stays active in overdischarge
module bpf_battery_protection_fsm
#(
   parameter int OVERCHARGE_CYC = bpf_pkg::BPF_OVERCHARGE_CYC,
   parameter int OVERDISCH_CYC  = bpf_pkg::BPF_OVERDISCH_CYC,
   parameter int OD_RELEASE_CYC = bpf_pkg::BPF_OD_RELEASE_CYC,
   parameter int DISCH_OC_CYC   = bpf_pkg::BPF_DISCH_OC_CYC,
   parameter int SHORT_CYC      = bpf_pkg::BPF_SHORT_CYC,
   parameter int CHARGE_OC_CYC  = bpf_pkg::BPF_CHARGE_OC_CYC
)
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // cell comparators (high when cell voltage is above the level)
   input  wire logic above_overcharge_detect_level,
   input  wire logic above_overcharge_release_level,
   input  wire logic above_overdischarge_detect_level,
   input  wire logic above_overdischarge_release_level,
   input  wire logic cell_above_zero_volt_level,
   // load_sense_pin comparators
   input  wire logic sense_at_discharge_overcurrent_level,
   input  wire logic sense_at_short_circuit_level,
   input  wire logic sense_at_charge_overcurrent_level,
   input  wire logic sense_below_charger_level,
   input  wire logic sense_near_ground,
   input  wire logic charger_overvoltage_detect,
   input  wire logic charger_overvoltage_release,
   // factory options, static after power-up
   input  wire logic option_power_down,
   input  wire logic option_zero_volt_charge,
   // switch and pull controls
   output logic      charge_switch_on,
   output logic      discharge_switch_on,
   output logic      sense_pullup_resistor_on,
   output logic      sense_pulldown_resistor_on,
   output logic      sleep_mode,
   output bpf_pkg::bpf_state_e state
);
   import bpf_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   localparam int NUM_IN = 14;
   localparam int TW     = BPF_TIMER_W;

   if (OVERCHARGE_CYC < 1 || OVERCHARGE_CYC >= (1 << TW) || OVERDISCH_CYC < 1 ||
       OVERDISCH_CYC >= (1 << TW) || OD_RELEASE_CYC < 1 || OD_RELEASE_CYC >= (1 << TW) ||
       DISCH_OC_CYC < 1 || DISCH_OC_CYC >= (1 << TW) || SHORT_CYC < 1 ||
       SHORT_CYC >= (1 << TW) || CHARGE_OC_CYC < 1 || CHARGE_OC_CYC >= (1 << TW))
   begin : g_bad_count
      $error("delay count out of range");
   end

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [NUM_IN-1:0] raw_in;
   logic [NUM_IN-1:0] sync_in;

   assign raw_in = {option_zero_volt_charge, option_power_down,
                    charger_overvoltage_release, charger_overvoltage_detect,
                    sense_near_ground, sense_below_charger_level,
                    sense_at_charge_overcurrent_level, sense_at_short_circuit_level,
                    sense_at_discharge_overcurrent_level, cell_above_zero_volt_level,
                    above_overdischarge_release_level, above_overdischarge_detect_level,
                    above_overcharge_release_level, above_overcharge_detect_level};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++)
      begin : g_sync
         logic [2:0] stage_reg;
         logic       value_reg;
         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
               stage_reg <= BPF_SYNC_RST;
            else
               stage_reg <= {stage_reg[1:0], raw_in[gi]};
         end
         // a change counts only once the last two stages agree
         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
               value_reg <= 1'b0;
            else if (stage_reg[1] == stage_reg[2])
               value_reg <= stage_reg[1];
         end
         assign sync_in[gi] = value_reg;
      end
   endgenerate

   // ----------------------------------------------------------------
   // warm-up: synchronisers read low until the real levels arrive
   // ----------------------------------------------------------------
   // without this a short delay count would act on a false low cell after reset
   logic [2:0] warm_reg;
   logic       warm;
   assign warm = (warm_reg == BPF_WARM_CYC);
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         warm_reg <= 3'h0;
      else if (!warm)
         warm_reg <= warm_reg + 3'h1;
   end

   logic oc_det;
   logic oc_rel;
   logic od_det;
   logic od_rel;
   logic cell_live;
   logic doc_lvl;
   logic short_lvl;
   logic coc_lvl;
   logic chg_lvl;
   logic near_gnd;
   logic ovc_det;
   logic ovc_rel;
   logic opt_pd;
   logic opt_zv;

   assign {opt_zv, opt_pd, ovc_rel, ovc_det, near_gnd, chg_lvl, coc_lvl, short_lvl,
           doc_lvl, cell_live, od_rel, od_det, oc_rel, oc_det} = sync_in;

   // ----------------------------------------------------------------
   // qualifying conditions and delay timers
   // ----------------------------------------------------------------
   bpf_state_e state_reg;
   logic [5:0] cond;
   logic [5:0] fired;
   logic [TW-1:0] limit [6];

   assign cond[0] = (state_reg == BPF_NORMAL) && oc_det;
   assign cond[1] = (state_reg == BPF_NORMAL) && !od_det;
   assign cond[2] = (state_reg == BPF_OVERDISCH) && !opt_pd && od_rel;
   assign cond[3] = (state_reg == BPF_NORMAL) && doc_lvl && !short_lvl;
   assign cond[4] = (state_reg == BPF_NORMAL) && short_lvl;
   assign cond[5] = (state_reg == BPF_NORMAL) && coc_lvl;

   assign limit[0] = TW'(OVERCHARGE_CYC);
   assign limit[1] = TW'(OVERDISCH_CYC);
   assign limit[2] = TW'(OD_RELEASE_CYC);
   assign limit[3] = TW'(DISCH_OC_CYC);
   assign limit[4] = TW'(SHORT_CYC);
   assign limit[5] = TW'(CHARGE_OC_CYC);

   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_timer
         logic [TW-1:0] count_reg;
         // a condition that drops restarts its timer from zero
         always_ff @(posedge clock or posedge rst)
         begin
            if (rst)
               count_reg <= '0;
            else if (!cond[gi] || !warm)
               count_reg <= '0;
            else if (count_reg != limit[gi])
               count_reg <= count_reg + TW'(1);
         end
         assign fired[gi] = cond[gi] && (count_reg == limit[gi]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // protection state machine
   // ----------------------------------------------------------------
   logic charger_present;
   assign charger_present = chg_lvl;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state_reg <= BPF_NORMAL;
      else
      begin
         unique case (state_reg)
            BPF_NORMAL:
            begin
               // short outranks the slower faults
               if (fired[4])
                  state_reg <= BPF_SHORT;
               else if (fired[3])
                  state_reg <= BPF_DISCH_OC;
               else if (fired[1])
                  state_reg <= BPF_OVERDISCH;
               else if (fired[0])
                  state_reg <= BPF_OVERCHARGE;
               else if (fired[5])
                  state_reg <= BPF_CHARGE_OC;
            end
            BPF_OVERCHARGE:
            begin
               if (!doc_lvl && !oc_rel)
                  state_reg <= BPF_NORMAL;
               else if (doc_lvl && !oc_det)
                  state_reg <= BPF_NORMAL;
            end
            BPF_OVERDISCH:
            begin
               if (charger_present && od_det)
                  state_reg <= BPF_NORMAL;
               else if (fired[2])
                  state_reg <= BPF_NORMAL;
            end
            BPF_DISCH_OC, BPF_SHORT:
            begin
               if (near_gnd)
                  state_reg <= BPF_NORMAL;
            end
            BPF_CHARGE_OC:
            begin
               // charge overcurrent ends when sense leaves the charge overcurrent level
               if (!coc_lvl)
                  state_reg <= BPF_NORMAL;
            end
            default:
               state_reg <= BPF_NORMAL;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // overvoltage charger latch, no delay either way
   // ----------------------------------------------------------------
   logic ovc_reg;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         ovc_reg <= 1'b0;
      else if (ovc_det)
         ovc_reg <= 1'b1;
      else if (!ovc_rel)
         ovc_reg <= 1'b0;
   end

   // ----------------------------------------------------------------
   // outputs, all from flip-flops
   // ----------------------------------------------------------------
   logic chg_next;
   logic dis_next;
   assign chg_next = (state_reg != BPF_OVERCHARGE) && (state_reg != BPF_CHARGE_OC) &&
                     !ovc_reg && (cell_live || opt_zv);
   assign dis_next = (state_reg == BPF_NORMAL) || (state_reg == BPF_OVERCHARGE) ||
                     (state_reg == BPF_CHARGE_OC);

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         charge_switch_on           <= 1'b0;
         discharge_switch_on        <= 1'b0;
         sense_pullup_resistor_on   <= 1'b0;
         sense_pulldown_resistor_on <= 1'b0;
         sleep_mode                 <= 1'b0;
         state                      <= BPF_NORMAL;
      end
      else
      begin
         charge_switch_on           <= chg_next;
         discharge_switch_on        <= dis_next;
         sense_pullup_resistor_on   <= (state_reg == BPF_OVERDISCH);
         sense_pulldown_resistor_on <= (state_reg == BPF_DISCH_OC) ||
                                       (state_reg == BPF_SHORT);
         sleep_mode                 <= (state_reg == BPF_OVERDISCH) && opt_pd;
         state                      <= state_reg;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_entered_od;
      state_reg != BPF_OVERDISCH ##1 state_reg == BPF_OVERDISCH;
   endsequence

   property p_normal_outputs;
      @(posedge clock) disable iff (rst)
      state_reg == BPF_NORMAL |=> discharge_switch_on && !sense_pullup_resistor_on &&
                                  !sense_pulldown_resistor_on;
   endproperty
   a_normal_outputs: assert property (p_normal_outputs) else $error("normal outputs wrong");

   property p_overcharge_entry;
      @(posedge clock) disable iff (rst)
      $rose(state_reg == BPF_OVERCHARGE) |-> $past(cond[0]) ##1 !charge_switch_on;
   endproperty
   a_overcharge_entry: assert property (p_overcharge_entry) else $error("overcharge entry");

   property p_overcharge_pulls;
      @(posedge clock) disable iff (rst)
      state_reg == BPF_OVERCHARGE |=> !sense_pullup_resistor_on && !sense_pulldown_resistor_on;
   endproperty
   a_overcharge_pulls: assert property (p_overcharge_pulls) else $error("pulls in overcharge");

   property p_od_pullup;
      @(posedge clock) disable iff (rst)
      s_entered_od |=> sense_pullup_resistor_on && !sense_pulldown_resistor_on &&
                       !discharge_switch_on;
   endproperty
   a_od_pullup: assert property (p_od_pullup) else $error("overdischarge pulls wrong");

   property p_pd_stays;
      @(posedge clock) disable iff (rst)
      state_reg == BPF_OVERDISCH && opt_pd && !charger_present |=> state_reg == BPF_OVERDISCH;
   endproperty
   a_pd_stays: assert property (p_pd_stays) else $error("power-down left without charger");

   property p_short_pulls;
      @(posedge clock) disable iff (rst)
      state_reg == BPF_SHORT || state_reg == BPF_DISCH_OC |=>
         sense_pulldown_resistor_on && !sense_pullup_resistor_on && !discharge_switch_on;
   endproperty
   a_short_pulls: assert property (p_short_pulls) else $error("overcurrent pulls wrong");

   property p_ovc_block;
      @(posedge clock) disable iff (rst)
      ovc_det |=> ##1 !charge_switch_on;
   endproperty
   a_ovc_block: assert property (p_ovc_block) else $error("overvoltage charger not blocked");

   property p_timer_restart;
      @(posedge clock) disable iff (rst)
      !cond[1] |=> !fired[1];
   endproperty
   a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted");

   property p_zero_volt;
      @(posedge clock) disable iff (rst)
      !cell_live && !opt_zv |=> !charge_switch_on;
   endproperty
   a_zero_volt: assert property (p_zero_volt) else $error("zero-volt charge not blocked");

endmodule

// [verification/bpf_pack_model.sv]
`timescale 1ns/1ps
module bpf_pack_model
#(
   parameter int OC_DET_MV  = 4375,
   parameter int OC_REL_MV  = 4175,
   parameter int OD_DET_MV  = 2500,
   parameter int OD_REL_MV  = 2900,
   parameter int ZERO_MV    = 300,
   parameter int DOC_MV     = 150,
   parameter int SHORT_MV   = 700,
   parameter int COC_MV     = -150,
   parameter int CHARGER_MV = -700,
   parameter int GROUND_MV  = 50,
   parameter int OV_DET_MV  = 8000,
   parameter int OV_REL_MV  = 7300
)
(
   // pack conditions set by the bench, in millivolts
   input  var int cell_mv,
   input  var int sense_mv,
   // comparator levels seen by the block
   output logic   ocd,
   output logic   ocr,
   output logic   odd,
   output logic   odr,
   output logic   zv,
   output logic   doc,
   output logic   sc,
   output logic   coc,
   output logic   chg,
   output logic   ng,
   output logic   ovd,
   output logic   ovr
);
   // ----------------------------------------------------------------
   // cell comparators
   // ----------------------------------------------------------------
   assign ocd = (cell_mv > OC_DET_MV);
   assign ocr = (cell_mv > OC_REL_MV);
   assign odd = (cell_mv > OD_DET_MV);
   assign odr = (cell_mv >= OD_REL_MV);
   assign zv  = (cell_mv > ZERO_MV);
   // ----------------------------------------------------------------
   // sense pin comparators; charger lifts supply-to-sense as well
   // ----------------------------------------------------------------
   assign doc = (sense_mv >= DOC_MV);
   assign sc  = (sense_mv >= SHORT_MV);
   assign coc = (sense_mv <= COC_MV);
   assign chg = (sense_mv < CHARGER_MV);
   assign ng  = (sense_mv < GROUND_MV) && (sense_mv > -GROUND_MV);
   assign ovd = ((cell_mv - sense_mv) > OV_DET_MV);
   assign ovr = ((cell_mv - sense_mv) > OV_REL_MV);
endmodule

// [verification/tb_bpf_battery_protection_fsm.sv]
`timescale 1ns/1ps
module tb_bpf_battery_protection_fsm;
   import bpf_pkg::*;
   // shortened delays keep the run brief; short is quicker so it wins
   localparam int N      = 4;
   localparam int SETTLE = 16;
   localparam int LIMIT  = 20000;
   logic       clock, rst, opt_pd, opt_zv;
   int         cell_mv, sense_mv, err_count, compares, cyc;
   logic       ocd, ocr, odd, odr, zv, doc, sc, coc, chg, ng, ovd, ovr;
   logic       chg_on, dis_on, pu_on, pd_on, sleep;
   bpf_state_e state;

   bpf_pack_model PACK (.cell_mv(cell_mv), .sense_mv(sense_mv), .ocd(ocd), .ocr(ocr),
      .odd(odd), .odr(odr), .zv(zv), .doc(doc), .sc(sc), .coc(coc), .chg(chg), .ng(ng),
      .ovd(ovd), .ovr(ovr));

   bpf_battery_protection_fsm #(.OVERCHARGE_CYC(N), .OVERDISCH_CYC(N), .OD_RELEASE_CYC(N),
      .DISCH_OC_CYC(N), .SHORT_CYC(2), .CHARGE_OC_CYC(N)) DUT (.clock(clock), .rst(rst),
      .above_overcharge_detect_level(ocd), .above_overcharge_release_level(ocr),
      .above_overdischarge_detect_level(odd), .above_overdischarge_release_level(odr),
      .cell_above_zero_volt_level(zv), .sense_at_discharge_overcurrent_level(doc),
      .sense_at_short_circuit_level(sc), .sense_at_charge_overcurrent_level(coc),
      .sense_below_charger_level(chg), .sense_near_ground(ng),
      .charger_overvoltage_detect(ovd), .charger_overvoltage_release(ovr),
      .option_power_down(opt_pd), .option_zero_volt_charge(opt_zv),
      .charge_switch_on(chg_on), .discharge_switch_on(dis_on),
      .sense_pullup_resistor_on(pu_on), .sense_pulldown_resistor_on(pd_on),
      .sleep_mode(sleep), .state(state));

   // ----------------------------------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         err_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("compares %0d, err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // drive just after an edge, then look just after the last edge
   task automatic step(input int c, input int s, input int n);
      @(posedge clock);
      #5;
      cell_mv  = c;
      sense_mv = s;
      repeat (n) @(posedge clock);
      #1;
   endtask

   // expected bits: charge, discharge, pull-up, pull-down, sleep
   task automatic chk(input logic [4:0] e, input bpf_state_e s);
      compares++;
      if ({chg_on, dis_on, pu_on, pd_on, sleep} !== e || state !== s)
      begin
         err_count++;
         $display("wrong value at %0t: got %h/%h expected %h/%h", $time,
                  {chg_on, dis_on, pu_on, pd_on, sleep}, state, e, s);
      end
   endtask

   // options only change under reset, as they are static in the field
   task automatic do_reset(input logic pd, input logic zvc, input int c);
      @(posedge clock);
      #5;
      rst      = 1'b1;
      opt_pd   = pd;
      opt_zv   = zvc;
      cell_mv  = c;
      sense_mv = 0;
      repeat (2) @(posedge clock);
      #1;
      chk(5'h00, BPF_NORMAL);
      #4;
      rst = 1'b0;
      repeat (SETTLE) @(posedge clock);
      #1;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_restart();
      for (int i = 0; i < 4; i++)
      begin
         step(4400, -50, 3);
         step(3700, -50, 2);
         chk(5'h18, BPF_NORMAL);
      end
      step(3700, 0, SETTLE);
      chk(5'h18, BPF_NORMAL);
   endtask

   task automatic t_overcharge();
      step(4400, -50, SETTLE);
      chk(5'h08, BPF_OVERCHARGE);
      step(4300, 0, SETTLE);
      chk(5'h08, BPF_OVERCHARGE);
      step(4100, 0, SETTLE);
      chk(5'h18, BPF_NORMAL);
      step(4400, -50, SETTLE);
      step(4300, 200, SETTLE);
      chk(5'h12, BPF_DISCH_OC);
      step(4100, 20, SETTLE);
      chk(5'h18, BPF_NORMAL);
   endtask

   task automatic t_short();
      step(3700, 900, SETTLE);
      chk(5'h12, BPF_SHORT);
      step(3700, 0, SETTLE);
      chk(5'h18, BPF_NORMAL);
   endtask

   task automatic t_coc_ov();
      step(3700, -200, SETTLE);
      chk(5'h08, BPF_CHARGE_OC);
      step(3700, 0, SETTLE);
      chk(5'h18, BPF_NORMAL);
      step(3700, -4500, 8);
      compares++;
      if (chg_on !== 1'b0)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, chg_on, 1'b0);
      end
      step(3700, 0, SETTLE);
      chk(5'h18, BPF_NORMAL);
   endtask

   task automatic t_od_power_down();
      step(2400, 0, SETTLE);
      chk(5'h15, BPF_OVERDISCH);
      step(3000, 0, SETTLE);
      chk(5'h15, BPF_OVERDISCH);
      step(3000, -800, SETTLE);
      chk(5'h08, BPF_CHARGE_OC);
      step(3700, 0, SETTLE);
      chk(5'h18, BPF_NORMAL);
   endtask

   task automatic t_od_auto();
      step(2400, 0, SETTLE);
      chk(5'h14, BPF_OVERDISCH);
      step(2700, 0, SETTLE);
      chk(5'h14, BPF_OVERDISCH);
      step(3000, 0, SETTLE);
      chk(5'h18, BPF_NORMAL);
   endtask

   task automatic t_zero_volt();
      do_reset(1'b0, 1'b0, 0);
      chk(5'h04, BPF_OVERDISCH);
      do_reset(1'b0, 1'b1, 0);
      chk(5'h14, BPF_OVERDISCH);
   endtask

   initial
   begin
      rst       = 1'b1;
      opt_pd    = 1'b1;
      opt_zv    = 1'b1;
      cell_mv   = 3700;
      sense_mv  = 0;
      err_count = 0;
      compares  = 0;
      cyc       = 0;
      do_reset(1'b1, 1'b1, 3700);
      t_restart();
      t_overcharge();
      t_short();
      t_coc_ov();
      t_od_power_down();
      do_reset(1'b0, 1'b1, 3700);
      t_od_auto();
      t_zero_volt();
      print_verdict();
   end
endmodule
